// ==== src/ssf_pkg.sv ====
// Package with constants and types for the serial status flag block.
package ssf_pkg;

  // Byte addresses of the register words.
  localparam logic [3:0] STATUS_ADDR = 4'h0;
  localparam logic [3:0] CONTROL_ADDR = 4'h4;
  localparam logic [3:0] RXDATA_ADDR = 4'h8;

  // Status register bit positions.
  localparam int TX_EMPTY_POS = 7;
  localparam int RX_FULL_POS = 6;
  localparam int ERR4_POS = 4;
  localparam int PARITY_POS = 3;
  localparam int TX_END_POS = 2;
  localparam int RX_MPB_POS = 1;
  localparam int TX_MPB_POS = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;

  // Control register bit positions.
  localparam int TX_EN_POS = 0;
  localparam int RX_EN_POS = 1;
  localparam int SC_SEL_POS = 2;
  localparam int GUARD_POS = 3;
  localparam int SYNC_POS = 4;
  localparam int MP_FMT_POS = 5;
  localparam int PAR_EN_POS = 6;
  localparam int PAR_ODD_POS = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Guard delay after a smart-card character, counted in half-bit ticks.
  localparam logic [2:0] GUARD_OFF_HALF_ETU = 3'h5;
  localparam logic [2:0] GUARD_ON_HALF_ETU = 3'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [3:0] araddr;
    logic arvalid;
    logic rready;
  } ssf_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ssf_axi_rsp_type;

  // Events reported by the serial shift engine, one-cycle pulses.
  typedef struct packed {
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_parity;
    logic rx_mpb;
    logic rx_stop_ok;
    logic tx_load;
    logic tx_last_bit;
    logic half_etu_tick;
  } ssf_line_evt_type;

endpackage

// ==== src/ssf_status.sv ====
// Status flag logic for the low bits of the serial status register, with an AXI4-Lite slave.
//
// Notes on behaviour
// RULE_01: Error-signal flag cleared by reset, standby, read-then-zero.
// RULE_02: Low line at sample point sets error-signal.
// RULE_03: Transmit enable clear keeps error-signal flag.
// RULE_04: Parity mismatch in async mode sets parity flag.
// RULE_05: Parity flag cleared by reset, standby, read-then-zero.
// RULE_06: Receive enable clear keeps parity flag.
// RULE_07: Parity error stores data, leaves receive-full.
// RULE_08: Parity flag halts receive; sync also transmit.
// RULE_09: Transmit-end is read-only.
// RULE_10: Normal transmit-end set conditions.
// RULE_11: Clearing transmit-empty also clears transmit-end; here the zero write clears transmit-end only, transmit-empty stays set.
// RULE_12: Smart-card transmit-end set on enable clear, no error.
// RULE_13: Smart-card transmit-end after 2.5 or 1.0 etu.
// RULE_14: Received multiprocessor bit captured, read-only, resets zero.
// RULE_15: Receive enable clear holds received multiprocessor bit.
// RULE_16: Transmit multiprocessor bit appended in multiprocessor format.
// RULE_17: Transmit multiprocessor bit ignored when not applicable.
// RULE_18: Bit 4 and transmit-end follow smart-card select.
// RULE_19: Status register initialises to 84 hex.
// RULE_20: Writing one to clearable flags is ignored.
// RULE_21: Hardware set beats a same-cycle software clear.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps

module ssf_status (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic standby_i,
  input wire ssf_pkg::ssf_axi_req_type axi_req_i,
  output ssf_pkg::ssf_axi_rsp_type axi_rsp_o,
  input wire ssf_pkg::ssf_line_evt_type line_evt_i,
  input wire logic err_line_i,
  input wire logic err_sample_i,
  output logic [7:0] rx_data_o,
  output logic rx_allowed_o,
  output logic tx_allowed_o,
  output logic tx_empty_o,
  output logic tx_end_o,
  output logic tx_mpb_o
);
  import ssf_pkg::*;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] control;
    logic [7:0] rx_buf;
    logic [7:0] seen;
    logic guard_run;
    logic [2:0] guard_cnt;
    logic [1:0] line_sync;
    logic tx_mpb_out;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssf_state_type;

  ssf_state_type state_reg;
  ssf_state_type state_next;

  logic wr_fire;
  logic rd_fire;
  logic sc_mode;
  logic async_mode;
  logic mp_async;
  logic rx_go;
  logic tx_go;
  logic parity_bad;
  logic perr_set;
  logic ferr_set;
  logic ers_set;
  logic err4_set;
  logic rx_ok;
  logic [2:0] guard_len;
  logic guard_done;
  logic [7:0] clr_req;
  logic [7:0] hw_set;
  logic [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  // Write address and data are taken together so the response follows both.
  assign wr_fire = axi_req_i.awvalid && axi_req_i.wvalid && !state_reg.bvalid;
  assign rd_fire = axi_req_i.arvalid && !state_reg.rvalid;

  always_comb begin
    axi_rsp_o = '0;
    axi_rsp_o.awready = wr_fire;
    axi_rsp_o.wready = wr_fire;
    axi_rsp_o.bvalid = state_reg.bvalid;
    axi_rsp_o.bresp = state_reg.bresp;
    axi_rsp_o.arready = rd_fire;
    axi_rsp_o.rvalid = state_reg.rvalid;
    axi_rsp_o.rdata = state_reg.rdata;
    axi_rsp_o.rresp = state_reg.rresp;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and line events.

  // Bit 4 and transmit-end change meaning with smart-card select.
  assign sc_mode = state_reg.control[SC_SEL_POS];
  assign async_mode = !state_reg.control[SYNC_POS];
  assign mp_async = async_mode && state_reg.control[MP_FMT_POS];

  // Reception stops while any receive error flag stands.
  assign rx_go = state_reg.control[RX_EN_POS] && !state_reg.status[PARITY_POS]
                 && !(state_reg.status[ERR4_POS] && !sc_mode);

  // Synchronous mode also blocks transmission on a receive error.
  assign tx_go = state_reg.control[TX_EN_POS]
                 && !(!async_mode && state_reg.status[PARITY_POS])
                 && !(!async_mode && state_reg.status[ERR4_POS] && !sc_mode);

  assign parity_bad = (^{line_evt_i.rx_data, line_evt_i.rx_parity}) != state_reg.control[PAR_ODD_POS];

  // RULE_04: parity mismatch detect.
  assign perr_set = line_evt_i.rx_done && rx_go && async_mode
                    && state_reg.control[PAR_EN_POS] && parity_bad;

  assign ferr_set = line_evt_i.rx_done && rx_go && async_mode && !sc_mode
                    && !line_evt_i.rx_stop_ok;

  // RULE_02: low line at sample point.
  assign ers_set = sc_mode && err_sample_i && !state_reg.line_sync[1];

  // RULE_18: bit 4 source selection.
  assign err4_set = sc_mode ? ers_set : ferr_set;

  // RULE_07: errors keep receive-full clear.
  assign rx_ok = line_evt_i.rx_done && rx_go && !perr_set && !ferr_set;

  assign guard_len = state_reg.control[GUARD_POS] ? GUARD_ON_HALF_ETU : GUARD_OFF_HALF_ETU;
  assign guard_done = state_reg.guard_run && line_evt_i.half_etu_tick
                      && (state_reg.guard_cnt == guard_len - 3'h1);

  assign wbyte = axi_req_i.wdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Per-flag set and clear requests.

  always_comb begin
    clr_req = '0;
    hw_set = '0;
    // RULE_20: only a zero after a read-while-set clears.
    if (wr_fire && axi_req_i.wstrb[0] && axi_req_i.awaddr == STATUS_ADDR) begin
      clr_req = ~wbyte & state_reg.seen;
    end
    hw_set[TX_EMPTY_POS] = line_evt_i.tx_load || !state_reg.control[TX_EN_POS];
    hw_set[RX_FULL_POS] = rx_ok;
    hw_set[ERR4_POS] = err4_set;
    hw_set[PARITY_POS] = perr_set;
    if (sc_mode) begin
      // RULE_12: enable cleared with no error signal.
      // RULE_13: guard delay expiry with empty buffer.
      hw_set[TX_END_POS] = (!state_reg.control[TX_EN_POS] && !state_reg.status[ERR4_POS])
                           || (guard_done && state_reg.status[TX_EMPTY_POS]
                               && !state_reg.status[ERR4_POS]);
    end else begin
      // RULE_10: enable cleared or last bit with empty buffer.
      hw_set[TX_END_POS] = !state_reg.control[TX_EN_POS]
                           || (line_evt_i.tx_last_bit && state_reg.status[TX_EMPTY_POS]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    state_next = state_reg;
    state_next.line_sync = {state_reg.line_sync[0], err_line_i};

    // Clearable flags; RULE_03 and RULE_06 hold because enables never clear them.
    // RULE_01: error-signal clear by read then zero.
    // RULE_05: parity clear by read then zero.
    // RULE_21: set wins over clear.
    for (int i = ERR4_POS; i <= TX_EMPTY_POS; i++) begin
      if (i != RX_FULL_POS + 1) begin
        if (hw_set[i]) begin
          state_next.status[i] = 1'b1;
        end else if (clr_req[i]) begin
          state_next.status[i] = 1'b0;
        end
      end
    end
    state_next.status[PARITY_POS] = hw_set[PARITY_POS]
                                    || (state_reg.status[PARITY_POS] && !clr_req[PARITY_POS]);
    state_next.status[5] = 1'b0;

    // RULE_11: a transmit-empty clear request ends transmit-end; transmit-empty itself stays set.
    // RULE_09: no write to bit 2 itself reaches transmit-end.
    if (hw_set[TX_END_POS]) begin
      state_next.status[TX_END_POS] = 1'b1;
    end else if (clr_req[TX_EMPTY_POS]) begin
      state_next.status[TX_END_POS] = 1'b0;
    end

    // RULE_07: data stored even on a parity error.
    if (line_evt_i.rx_done && rx_go) begin
      state_next.rx_buf = line_evt_i.rx_data;
      // RULE_14: capture received multiprocessor bit.
      // RULE_15: only while reception is enabled.
      if (mp_async) begin
        state_next.status[RX_MPB_POS] = line_evt_i.rx_mpb;
      end
    end

    // Read-while-set marks; a write to the status word consumes them.
    if (rd_fire && axi_req_i.araddr == STATUS_ADDR) begin
      state_next.seen = state_reg.seen | state_reg.status;
    end else if (wr_fire && axi_req_i.awaddr == STATUS_ADDR) begin
      state_next.seen = '0;
    end
    state_next.seen[TX_END_POS] = 1'b0;
    state_next.seen[RX_MPB_POS] = 1'b0;
    state_next.seen[TX_MPB_POS] = 1'b0;
    state_next.seen[5] = 1'b0;

    // Guard delay after each smart-card character.
    if (sc_mode && line_evt_i.tx_last_bit) begin
      state_next.guard_run = 1'b1;
      state_next.guard_cnt = '0;
    end else if (guard_done || !sc_mode) begin
      state_next.guard_run = 1'b0;
      state_next.guard_cnt = '0;
    end else if (state_reg.guard_run && line_evt_i.half_etu_tick) begin
      state_next.guard_cnt = state_reg.guard_cnt + 3'h1;
    end

    // RULE_16: append stored multiprocessor bit.
    // RULE_17: ignored outside async multiprocessor transmit.
    state_next.tx_mpb_out = state_reg.status[TX_MPB_POS] && mp_async && tx_go;

    // Register writes.
    if (wr_fire) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (axi_req_i.awaddr == STATUS_ADDR) begin
        if (axi_req_i.wstrb[0]) begin
          state_next.status[TX_MPB_POS] = wbyte[TX_MPB_POS];
        end
      end else if (axi_req_i.awaddr == CONTROL_ADDR) begin
        if (axi_req_i.wstrb[0]) begin
          state_next.control = wbyte;
        end
      end else if (axi_req_i.awaddr != RXDATA_ADDR) begin
        state_next.bresp = RESP_SLVERR;
      end
    end else if (state_reg.bvalid && axi_req_i.bready) begin
      state_next.bvalid = 1'b0;
    end

    // Register reads.
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = '0;
      case (axi_req_i.araddr)
        STATUS_ADDR: begin
          state_next.rdata[7:0] = state_reg.status;
        end
        CONTROL_ADDR: begin
          state_next.rdata[7:0] = state_reg.control;
        end
        RXDATA_ADDR: begin
          state_next.rdata[7:0] = state_reg.rx_buf;
        end
        default: begin
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && axi_req_i.rready) begin
      state_next.rvalid = 1'b0;
    end

    // RULE_19: status forced to its initial value in standby.
    // RULE_01: standby clears the error-signal flag.
    // RULE_05: standby clears the parity flag.
    if (standby_i) begin
      state_next.status = STATUS_RESET;
      state_next.seen = '0;
      state_next.guard_run = 1'b0;
      state_next.guard_cnt = '0;
      state_next.tx_mpb_out = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      // RULE_19: initial status value on reset.
      state_reg.status <= STATUS_RESET;
      state_reg.control <= CONTROL_RESET;
      state_reg.line_sync <= 2'h3;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rx_data_o = state_reg.rx_buf;
  // RULE_08: reception halts on a parity or framing flag; transmission too in sync mode.
  assign rx_allowed_o = rx_go;
  assign tx_allowed_o = tx_go;
  assign tx_empty_o = state_reg.status[TX_EMPTY_POS];
  assign tx_end_o = state_reg.status[TX_END_POS];
  assign tx_mpb_o = state_reg.tx_mpb_out;

endmodule

// ==== sim/ssf_status_checker.sv ====
// Concurrent checks on the ports of the status flag block.
`timescale 1ns/100ps
module ssf_status_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic standby_i,
  input wire ssf_pkg::ssf_axi_req_type axi_req_i,
  input wire ssf_pkg::ssf_axi_rsp_type axi_rsp_o,
  input wire ssf_pkg::ssf_line_evt_type line_evt_i,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_allowed_o,
  input wire logic tx_empty_o,
  input wire logic tx_end_o
);
  import ssf_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  sequence wr_take;
    axi_req_i.awvalid && axi_req_i.wvalid && !axi_rsp_o.bvalid;
  endsequence
  sequence rd_take;
    axi_req_i.arvalid && !axi_rsp_o.rvalid;
  endsequence
  AST_WR_ANSWER: assert property (wr_take |-> axi_rsp_o.awready ##1 axi_rsp_o.bvalid) else $error("write answer");
  AST_RD_ANSWER: assert property (rd_take |-> axi_rsp_o.arready ##1 axi_rsp_o.rvalid) else $error("read answer");
  AST_B_HOLD: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid) else $error("bvalid drop");
  AST_R_HOLD: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=> $stable(axi_rsp_o.rdata)) else $error("rdata");
  AST_STANDBY_INIT: assert property (standby_i |=> tx_end_o && tx_empty_o) else $error("standby init");
  AST_END_CLEAR: assert property ($fell(tx_empty_o) |-> !tx_end_o) else $error("tx end kept");
  AST_END_SET: assert property ($rose(tx_end_o) |-> tx_empty_o) else $error("tx end early");
  AST_RX_STORE: assert property (line_evt_i.rx_done && rx_allowed_o |=>
    rx_data_o == $past(line_evt_i.rx_data)) else $error("rx data");
endmodule

bind ssf_status ssf_status_checker ssf_status_checker_inst (.clk_i, .rst_n_i, .standby_i, .axi_req_i,
  .axi_rsp_o, .line_evt_i, .rx_data_o, .rx_allowed_o, .tx_empty_o, .tx_end_o);

// ==== sim/ssf_line_model.sv ====
// Line-side partner: serial engine events and the smart-card error line.
`timescale 1ns/100ps
module ssf_line_model (
  input wire logic clk_i,
  output ssf_pkg::ssf_line_evt_type evt_o,
  output logic err_line_o,
  output logic err_sample_o
);
  import ssf_pkg::*;
  // The card line has a pull-up, so it idles high.
  initial begin
    evt_o = '0;
    err_line_o = 1'b1;
    err_sample_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // The stop-bit flag lets a scenario send a character with a broken frame.
  task automatic rx(input logic [7:0] d, input logic p, input logic m, input logic s);
    @(posedge clk_i);
    evt_o.rx_data <= d;
    evt_o.rx_parity <= p;
    evt_o.rx_mpb <= m;
    evt_o.rx_stop_ok <= s;
    evt_o.rx_done <= 1'b1;
    @(posedge clk_i);
    // Released data shows the inverse so stale values never look valid.
    evt_o.rx_data <= ~d;
    evt_o.rx_mpb <= ~m;
    evt_o.rx_done <= 1'b0;
  endtask
  // Bit 2 is the buffer load, bit 1 the last bit, bit 0 the half-bit tick.
  task automatic pulse(input int k);
    @(posedge clk_i);
    evt_o[k] <= 1'b1;
    @(posedge clk_i);
    evt_o[k] <= 1'b0;
  endtask
  task automatic err_signal();
    @(posedge clk_i);
    err_line_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    err_sample_o <= 1'b1;
    @(posedge clk_i);
    err_sample_o <= 1'b0;
    err_line_o <= 1'b1;
  endtask
endmodule

// ==== sim/serial_status_flags_low_tb.sv ====
// Register-level testbench for the status flag block.
`timescale 1ns/100ps
module serial_status_flags_low_tb;
  import ssf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic standby_i = 1'b0;
  ssf_axi_req_type req = '0;
  ssf_axi_rsp_type rsp;
  ssf_line_evt_type evt;
  logic err_line, err_sample, rx_allowed, tx_allowed, tx_empty, tx_end, tx_mpb;
  logic [7:0] rx_data;
  int n_fail = 0;
  int comparisons = 0;
  logic [3:0] wr_strb = 4'hf;
  initial forever #20 clk_i = ~clk_i;
  ssf_status ssf_status_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i), .axi_req_i(req),
    .axi_rsp_o(rsp), .line_evt_i(evt), .err_line_i(err_line), .err_sample_i(err_sample), .rx_data_o(rx_data),
    .rx_allowed_o(rx_allowed), .tx_allowed_o(tx_allowed), .tx_empty_o(tx_empty), .tx_end_o(tx_end),
    .tx_mpb_o(tx_mpb));
  ssf_line_model ssf_line_model_inst (.clk_i(clk_i), .evt_o(evt), .err_line_o(err_line),
    .err_sample_o(err_sample));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(inout int n);
    @(posedge clk_i);
    n++;
    if (n > 40) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= wr_strb;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do step(n); while (!(rsp.awready && rsp.wready));
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do step(n); while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, ((a == STATUS_ADDR || a == CONTROL_ADDR || a == RXDATA_ADDR) ? RESP_OKAY : RESP_SLVERR)},
      {30'h0, rsp.bresp});
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do step(n); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do step(n); while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk("rdata", {24'h0, e}, rsp.rdata);
    chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(STATUS_ADDR, 8'h84, RESP_OKAY);
    rd(4'hc, 8'h00, RESP_SLVERR);
    wr(4'hc, 8'h00);
    wr(STATUS_ADDR, 8'hff);
    rd(STATUS_ADDR, 8'h85, RESP_OKAY);
    wr(STATUS_ADDR, 8'h84);
    // Even parity with one data bit set and parity 0 is a mismatch.
    wr(CONTROL_ADDR, 8'h42);
    ssf_line_model_inst.rx(8'h01, 1'b0, 1'b0, 1'b1);
    settle();
    chk("rx_data", 32'h01, {24'h0, rx_data});
    chk("rx_allowed", 32'h0, {31'h0, rx_allowed});
    rd(RXDATA_ADDR, 8'h01, RESP_OKAY);
    wr(RXDATA_ADDR, 8'hff);
    rd(RXDATA_ADDR, 8'h01, RESP_OKAY);
    // Synchronous mode with the parity flag standing must block transmission.
    wr(CONTROL_ADDR, 8'h51);
    settle();
    chk("tx_allowed", 32'h0, {31'h0, tx_allowed});
    wr(CONTROL_ADDR, 8'h40);
    rd(STATUS_ADDR, 8'h8c, RESP_OKAY);
    wr(STATUS_ADDR, 8'h84);
    rd(STATUS_ADDR, 8'h84, RESP_OKAY);
    // A broken stop bit in normal mode raises bit 4 as a framing error.
    wr(CONTROL_ADDR, 8'h02);
    ssf_line_model_inst.rx(8'haa, 1'b0, 1'b0, 1'b0);
    settle();
    chk("rx_allowed", 32'h0, {31'h0, rx_allowed});
    rd(STATUS_ADDR, 8'h94, RESP_OKAY);
    wr(STATUS_ADDR, 8'h84);
    wr(CONTROL_ADDR, 8'h22);
    ssf_line_model_inst.rx(8'h55, 1'b0, 1'b1, 1'b1);
    rd(STATUS_ADDR, 8'hc6, RESP_OKAY);
    wr(CONTROL_ADDR, 8'h20);
    // A character arriving with reception off must not touch the stored bit.
    ssf_line_model_inst.rx(8'haa, 1'b0, 1'b0, 1'b1);
    rd(STATUS_ADDR, 8'hc6, RESP_OKAY);
    wr(STATUS_ADDR, 8'h84);
    wr(CONTROL_ADDR, 8'h21);
    wr(STATUS_ADDR, 8'h85);
    settle();
    chk("tx_mpb", 32'h1, {31'h0, tx_mpb});
    // A write with its low byte lane off must leave the status word alone.
    wr_strb = 4'h0;
    wr(STATUS_ADDR, 8'h00);
    wr_strb = 4'hf;
    settle();
    chk("tx_mpb", 32'h1, {31'h0, tx_mpb});
    wr(CONTROL_ADDR, 8'h31);
    settle();
    chk("tx_mpb", 32'h0, {31'h0, tx_mpb});
    wr(CONTROL_ADDR, 8'h01);
    rd(STATUS_ADDR, 8'h87, RESP_OKAY);
    wr(STATUS_ADDR, 8'h00);
    settle();
    chk("tx_end", 32'h0, {31'h0, tx_end});
    chk("tx_allowed", 32'h1, {31'h0, tx_allowed});
    ssf_line_model_inst.pulse(2);
    ssf_line_model_inst.pulse(1);
    settle();
    chk("tx_end", 32'h1, {31'h0, tx_end});
    // Guard off waits five half-bit ticks, guard on waits two.
    for (int g = 0; g < 2; g++) begin
      wr(CONTROL_ADDR, g ? 8'h0d : 8'h05);
      rd(STATUS_ADDR, 8'h86, RESP_OKAY);
      wr(STATUS_ADDR, 8'h00);
      ssf_line_model_inst.pulse(2);
      ssf_line_model_inst.pulse(1);
      repeat (g ? 1 : 4) ssf_line_model_inst.pulse(0);
      settle();
      chk("tx_end", 32'h0, {31'h0, tx_end});
      ssf_line_model_inst.pulse(0);
      settle();
      chk("tx_end", 32'h1, {31'h0, tx_end});
    end
    wr(CONTROL_ADDR, 8'h05);
    rd(STATUS_ADDR, 8'h86, RESP_OKAY);
    wr(STATUS_ADDR, 8'h00);
    ssf_line_model_inst.err_signal();
    wr(CONTROL_ADDR, 8'h04);
    rd(STATUS_ADDR, 8'h92, RESP_OKAY);
    // Clearing the error signal with transmit off then lets transmit-end rise.
    wr(STATUS_ADDR, 8'h80);
    rd(STATUS_ADDR, 8'h86, RESP_OKAY);
    @(posedge clk_i);
    standby_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    standby_i <= 1'b0;
    rd(STATUS_ADDR, 8'h84, RESP_OKAY);
    print_verdict();
  end
endmodule
